// File: dacr_regs.sv
// Per-channel address and count registers with APB slave and descriptor stream
`default_nettype none
module dacr_regs #(
  parameter int unsigned NUM_CH = 6,
  parameter int unsigned NUM_SH = 4
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    step_valid,
  input  wire logic [2:0]              step_ch,
  output logic                         step_ready,
  output logic                         desc_valid,
  input  wire logic                    desc_ready,
  output dacr_pkg::dacr_desc_s         desc,
  output logic [NUM_CH-1:0]            chan_active
);
  logic [31:0] src_q    [NUM_CH];
  logic [31:0] src_d    [NUM_CH];
  logic [31:0] dst_q    [NUM_CH];
  logic [31:0] dst_d    [NUM_CH];
  logic [23:0] cnt_q    [NUM_CH];
  logic [23:0] cnt_d    [NUM_CH];
  logic [31:0] src_sh_q [NUM_CH];
  logic [31:0] src_sh_d [NUM_CH];
  logic [31:0] dst_sh_q [NUM_CH];
  logic [31:0] dst_sh_d [NUM_CH];
  logic [23:0] cnt_sh_q [NUM_CH];
  logic [23:0] cnt_sh_d [NUM_CH];
  logic [31:0] cfg_q    [NUM_CH];
  logic [31:0] cfg_d    [NUM_CH];
  logic [NUM_CH-1:0] hit_src;
  logic [NUM_CH-1:0] hit_dst;
  logic [NUM_CH-1:0] hit_cnt;
  logic [NUM_CH-1:0] hit_ssrc;
  logic [NUM_CH-1:0] hit_sdst;
  logic [NUM_CH-1:0] hit_scnt;
  logic [NUM_CH-1:0] hit_cfg;
  logic [31:0]       rd_data;
  logic              rd_hit;
  logic [31:0]       prdata_q;
  logic              err_q;
  logic              wr_fire;
  logic              step_fire;
  logic              ch_ok;
  logic              buf_in_ready;
  logic              step_last;
  dacr_pkg::dacr_desc_s push_desc;
  dacr_pkg::dacr_desc_s pop_desc;

  function automatic logic [11:0] ch_base(input int unsigned c);
    int unsigned slot;
    slot = (c >= dacr_pkg::CH_GAP_FROM) ? c + 1 : c;
    ch_base = 12'(slot * 16);
  endfunction : ch_base

  function automatic logic [31:0] unit_bytes(input logic [2:0] size);
    case (size)
      dacr_pkg::SIZE_WORD: unit_bytes = 32'h0000_0002;
      dacr_pkg::SIZE_LONG: unit_bytes = 32'h0000_0004;
      dacr_pkg::SIZE_8B:   unit_bytes = 32'h0000_0008;
      dacr_pkg::SIZE_16B:  unit_bytes = 32'h0000_0010;
      dacr_pkg::SIZE_32B:  unit_bytes = 32'h0000_0020;
      default:             unit_bytes = 32'h0000_0001;
    endcase
  endfunction : unit_bytes

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = wd[8*b +: 8];
    end
    merge = r;
  endfunction : merge

  function automatic logic [2:0] rpt_of(input logic [31:0] cfg);
    rpt_of = cfg[dacr_pkg::CFG_RPT_LO +: 3];
  endfunction : rpt_of

  // Address decode
  for (genvar c = 0; c < NUM_CH; c++) begin : g_dec
    localparam logic [11:0] SH_OFS = 12'(c * 16);
    assign hit_src[c] = (paddr == 12'(dacr_pkg::OFS_SRC + ch_base(c)));
    assign hit_dst[c] = (paddr == 12'(dacr_pkg::OFS_DST + ch_base(c)));
    assign hit_cnt[c] = (paddr == 12'(dacr_pkg::OFS_CNT + ch_base(c)));
    assign hit_cfg[c] = (paddr == 12'(dacr_pkg::OFS_CFG + 12'(c * 4)));
    if (c < NUM_SH) begin : g_sh
      assign hit_ssrc[c] = (paddr == 12'(dacr_pkg::OFS_SH_SRC + SH_OFS));
      assign hit_sdst[c] = (paddr == 12'(dacr_pkg::OFS_SH_DST + SH_OFS));
      assign hit_scnt[c] = (paddr == 12'(dacr_pkg::OFS_SH_CNT + SH_OFS));
    end else begin : g_nosh
      assign hit_ssrc[c] = 1'b0;
      assign hit_sdst[c] = 1'b0;
      assign hit_scnt[c] = 1'b0;
    end
  end

  assign rd_hit = |{hit_src, hit_dst, hit_cnt, hit_ssrc, hit_sdst, hit_scnt, hit_cfg};

  always_comb begin
    rd_data = dacr_pkg::RESET_WORD;
    for (int c = 0; c < NUM_CH; c++) begin
      if (hit_src[c]) rd_data = src_q[c];
      else if (hit_dst[c]) rd_data = dst_q[c];
      else if (hit_cnt[c]) rd_data = {dacr_pkg::CNT_TOP_ZERO, cnt_q[c]}; // RULE_13
      else if (hit_ssrc[c]) rd_data = src_sh_q[c];
      else if (hit_sdst[c]) rd_data = dst_sh_q[c];
      else if (hit_scnt[c]) rd_data = {dacr_pkg::CNT_TOP_ZERO, cnt_sh_q[c]};
      else if (hit_cfg[c]) rd_data = cfg_q[c];
    end
  end

  // APB: read data is captured in setup, so the access phase never waits
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = psel && penable && err_q;
  assign wr_fire = psel && penable && pwrite && !err_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= dacr_pkg::RESET_WORD;
      err_q    <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? dacr_pkg::RESET_WORD : rd_data;
      err_q    <= !rd_hit;
    end
  end

  // Transfer stepping; a full buffer stalls the requester
  assign ch_ok      = (step_ch < 3'(NUM_CH)) && cfg_q[step_ch][dacr_pkg::CFG_EN];
  assign step_ready = buf_in_ready && ch_ok;
  assign step_fire  = step_valid && step_ready;
  assign step_last  = (cnt_q[step_ch] == dacr_pkg::CNT_LAST); // RULE_11

  assign push_desc.ch   = step_ch;
  assign push_desc.src  = src_q[step_ch];
  assign push_desc.dst  = dst_q[step_ch];
  assign push_desc.last = step_last;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      logic [2:0]  rpt;
      logic [31:0] step_sz;
      rpt         = rpt_of(cfg_q[c]);
      step_sz     = unit_bytes(cfg_q[c][dacr_pkg::CFG_SIZE_LO +: 3]);
      src_d[c]    = src_q[c];
      dst_d[c]    = dst_q[c];
      cnt_d[c]    = cnt_q[c];
      src_sh_d[c] = src_sh_q[c];
      dst_sh_d[c] = dst_sh_q[c];
      cnt_sh_d[c] = cnt_sh_q[c];
      cfg_d[c]    = cfg_q[c];
      if (step_fire && (step_ch == 3'(c))) begin
        if (cfg_q[c][dacr_pkg::CFG_SRC_INC]) src_d[c] = src_q[c] + step_sz; // RULE_01 RULE_15
        if (cfg_q[c][dacr_pkg::CFG_DST_INC]) dst_d[c] = dst_q[c] + step_sz; // RULE_07 RULE_15
        cnt_d[c] = cnt_q[c] - dacr_pkg::CNT_ONE; // RULE_12 RULE_11
        if (cnt_q[c] == dacr_pkg::CNT_LAST) begin
          case (rpt) // RULE_17
            dacr_pkg::RPT_SDC, dacr_pkg::RPT_RELOAD: begin
              src_d[c] = src_sh_q[c]; // RULE_04
              dst_d[c] = dst_sh_q[c]; // RULE_08
              cnt_d[c] = cnt_sh_q[c];
            end
            dacr_pkg::RPT_DC: begin
              dst_d[c] = dst_sh_q[c]; // RULE_08
              cnt_d[c] = cnt_sh_q[c];
            end
            dacr_pkg::RPT_SC: begin
              src_d[c] = src_sh_q[c]; // RULE_04
              cnt_d[c] = cnt_sh_q[c];
            end
            default: cfg_d[c][dacr_pkg::CFG_EN] = 1'b0;
          endcase
        end
      end
      // A register write in the same cycle overrides the stepped value
      if (wr_fire && hit_src[c]) begin
        src_d[c] = merge(src_q[c], pwdata, pstrb);
        if (c < NUM_SH) src_sh_d[c] = merge(src_q[c], pwdata, pstrb); // RULE_05
      end
      if (wr_fire && hit_dst[c]) begin
        dst_d[c] = merge(dst_q[c], pwdata, pstrb);
        if (c < NUM_SH) dst_sh_d[c] = merge(dst_q[c], pwdata, pstrb); // RULE_09
      end
      if (wr_fire && hit_cnt[c]) begin
        cnt_d[c] = 24'(merge({dacr_pkg::CNT_TOP_ZERO, cnt_q[c]}, pwdata, pstrb)); // RULE_13
        if (c < NUM_SH) cnt_sh_d[c] = cnt_d[c]; // RULE_16
      end
      if (wr_fire && hit_ssrc[c]) src_sh_d[c] = merge(src_sh_q[c], pwdata, pstrb);
      if (wr_fire && hit_sdst[c]) dst_sh_d[c] = merge(dst_sh_q[c], pwdata, pstrb);
      if (wr_fire && hit_scnt[c]) cnt_sh_d[c] = 24'(merge({8'h00, cnt_sh_q[c]}, pwdata, pstrb));
      if (wr_fire && hit_cfg[c]) begin
        cfg_d[c] = merge(cfg_q[c], pwdata, pstrb) & dacr_pkg::CFG_MASK;
        // Renewal has no shadow set behind it on the upper channels
        if (c >= NUM_SH) cfg_d[c] = cfg_d[c] & ~dacr_pkg::CFG_RPT_MASK;
      end
    end
  end

  // Only power-on reset clears; there is no low-power clear path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_CH; c++) begin
        src_q[c]    <= dacr_pkg::RESET_WORD; // RULE_14
        dst_q[c]    <= dacr_pkg::RESET_WORD;
        cnt_q[c]    <= '0;
        src_sh_q[c] <= dacr_pkg::RESET_WORD;
        dst_sh_q[c] <= dacr_pkg::RESET_WORD;
        cnt_sh_q[c] <= '0;
        cfg_q[c]    <= dacr_pkg::RESET_WORD;
      end
    end else begin
      src_q    <= src_d;
      dst_q    <= dst_d;
      cnt_q    <= cnt_d;
      src_sh_q <= src_sh_d;
      dst_sh_q <= dst_sh_d;
      cnt_sh_q <= cnt_sh_d;
      cfg_q    <= cfg_d;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_act
    assign chan_active[c] = cfg_q[c][dacr_pkg::CFG_EN];
  end

  dacr_buf #(
    .W     ($bits(dacr_pkg::dacr_desc_s)),
    .DEPTH (2)
  ) u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (step_fire),
    .in_ready  (buf_in_ready),
    .in_data   (push_desc),
    .out_valid (desc_valid),
    .out_ready (desc_ready),
    .out_data  (pop_desc)
  );
  assign desc = pop_desc;

  // Checks on channel 0 and 1 behaviour
  logic ch0_fire;
  logic quiet;
  assign ch0_fire = step_fire && (step_ch == 3'h0);
  assign quiet    = !(psel && penable && pwrite);

  sequence s_ch0_mid;
    ch0_fire && quiet && (cnt_q[0] != dacr_pkg::CNT_LAST);
  endsequence
  sequence s_ch0_end;
    ch0_fire && quiet && (cnt_q[0] == dacr_pkg::CNT_LAST);
  endsequence

  property p_src_adv;
    @(posedge pclk) disable iff (!presetn)
      s_ch0_mid ##0 cfg_q[0][dacr_pkg::CFG_SRC_INC]
      |=> src_q[0] == $past(src_q[0]) + unit_bytes(cfg_q[0][dacr_pkg::CFG_SIZE_LO +: 3]);
  endproperty
  a_src_adv: assert property (p_src_adv) else $error("source address did not advance"); // RULE_01

  property p_dst_hold;
    @(posedge pclk) disable iff (!presetn)
      s_ch0_mid ##0 !cfg_q[0][dacr_pkg::CFG_DST_INC] |=> $stable(dst_q[0]);
  endproperty
  a_dst_hold: assert property (p_dst_hold) else $error("fixed destination moved"); // RULE_15

  property p_dst_adv;
    @(posedge pclk) disable iff (!presetn)
      s_ch0_mid ##0 cfg_q[0][dacr_pkg::CFG_DST_INC]
      |=> dst_q[0] == $past(dst_q[0]) + unit_bytes(cfg_q[0][dacr_pkg::CFG_SIZE_LO +: 3]);
  endproperty
  a_dst_adv: assert property (p_dst_adv) else $error("destination address did not advance"); // RULE_07

  property p_cnt_dec;
    @(posedge pclk) disable iff (!presetn)
      s_ch0_mid |=> cnt_q[0] == $past(cnt_q[0]) - dacr_pkg::CNT_ONE;
  endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("count did not decrement"); // RULE_12

  property p_max_count;
    @(posedge pclk) disable iff (!presetn)
      ch0_fire && quiet && (cnt_q[0] == '0) |-> !step_last ##1 (cnt_q[0] == 24'hff_ffff);
  endproperty
  a_max_count: assert property (p_max_count) else $error("zero count not treated as maximum"); // RULE_11

  property p_src_reload;
    @(posedge pclk) disable iff (!presetn)
      s_ch0_end ##0 (rpt_of(cfg_q[0]) == dacr_pkg::RPT_SDC)
      |=> (src_q[0] == $past(src_sh_q[0])) && (cnt_q[0] == $past(cnt_sh_q[0]));
  endproperty
  a_src_reload: assert property (p_src_reload) else $error("repeat did not restore source"); // RULE_04

  property p_dst_reload;
    @(posedge pclk) disable iff (!presetn)
      s_ch0_end ##0 (rpt_of(cfg_q[0]) == dacr_pkg::RPT_DC) |=> dst_q[0] == $past(dst_sh_q[0]);
  endproperty
  a_dst_reload: assert property (p_dst_reload) else $error("repeat did not restore destination"); // RULE_08

  property p_normal_end;
    @(posedge pclk) disable iff (!presetn)
      s_ch0_end ##0 (rpt_of(cfg_q[0]) == dacr_pkg::RPT_NORMAL)
      |=> !chan_active[0] && ((step_ch != 3'h0) || !step_ready);
  endproperty
  a_normal_end: assert property (p_normal_end) else $error("normal mode channel kept running"); // RULE_17

  property p_src_mirror;
    @(posedge pclk) disable iff (!presetn)
      wr_fire && hit_src[0] && (pstrb == 4'hf) |=> (src_q[0] == $past(pwdata)) && (src_sh_q[0] == $past(pwdata));
  endproperty
  a_src_mirror: assert property (p_src_mirror) else $error("source write not mirrored"); // RULE_05

  property p_dst_mirror;
    @(posedge pclk) disable iff (!presetn)
      wr_fire && hit_dst[1] && (pstrb == 4'hf) |=> (dst_q[1] == $past(pwdata)) && (dst_sh_q[1] == $past(pwdata));
  endproperty
  a_dst_mirror: assert property (p_dst_mirror) else $error("destination write not mirrored"); // RULE_09

  property p_cnt_mirror;
    @(posedge pclk) disable iff (!presetn)
      wr_fire && hit_cnt[0] && (pstrb == 4'hf) |=> cnt_sh_q[0] == $past(pwdata[23:0]);
  endproperty
  a_cnt_mirror: assert property (p_cnt_mirror) else $error("count write not mirrored"); // RULE_16

  property p_cnt_top;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && hit_cnt[0] ##1 psel && penable |-> prdata[31:24] == 8'h00;
  endproperty
  a_cnt_top: assert property (p_cnt_top) else $error("count top byte not zero"); // RULE_13
endmodule : dacr_regs
`default_nettype wire

// File: dacr_pkg.sv
// Constants, offsets and carrier types for the DMA address and count register block
//
// Summary of operation
// RULE_01: Working source address advances, shows next read
// RULE_02: Software aligns word and longword addresses
// RULE_03: Software aligns 8/16/32-byte unit addresses
// RULE_04: Channels 0-3 restore source from shadow copy
// RULE_05: Writing working source also writes shadow source
// RULE_06: Software writes shadow after working for differences
// RULE_07: Working destination advances, shows next write
// RULE_08: Channels 0-3 restore destination from shadow copy
// RULE_09: Writing working destination also writes shadow
// RULE_10: Software writes shadow destination after working one
// RULE_11: Count one is one, zero is maximum
// RULE_12: Count decrements, shows transfers still remaining
// RULE_13: Count top byte reads zero, write zero
// RULE_14: Power-on reset clears, low power retains
// RULE_15: Addresses step by unit size or hold
// RULE_16: Writing working count also writes shadow count
// RULE_17: Renewal field picks normal, repeat or reload
`default_nettype none
package dacr_pkg;
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned CNT_W        = 24;
  localparam int unsigned CH_W         = 3;
  localparam logic [11:0] OFS_SRC      = 12'h020;
  localparam logic [11:0] OFS_DST      = 12'h024;
  localparam logic [11:0] OFS_CNT      = 12'h028;
  localparam logic [11:0] CH_STRIDE    = 12'h010;
  localparam logic [11:0] OFS_SH_SRC   = 12'h120;
  localparam logic [11:0] OFS_SH_DST   = 12'h124;
  localparam logic [11:0] OFS_SH_CNT   = 12'h128;
  localparam logic [11:0] OFS_CFG      = 12'h200;
  localparam logic [11:0] CFG_STRIDE   = 12'h004;
  localparam int unsigned CH_GAP_FROM  = 4;
  localparam int unsigned CFG_EN       = 0;
  localparam int unsigned CFG_SRC_INC  = 4;
  localparam int unsigned CFG_DST_INC  = 5;
  localparam int unsigned CFG_SIZE_LO  = 8;
  localparam int unsigned CFG_RPT_LO   = 25;
  localparam logic [31:0] CFG_MASK     = 32'h0e00_0731;
  localparam logic [31:0] CFG_RPT_MASK = 32'h0e00_0000;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [23:0] CNT_LAST     = 24'h00_0001;
  localparam logic [23:0] CNT_ONE      = 24'h00_0001;
  localparam logic [7:0]  CNT_TOP_ZERO = 8'h00;

  typedef enum logic [2:0] {
    SIZE_BYTE = 3'h0,
    SIZE_WORD = 3'h1,
    SIZE_LONG = 3'h2,
    SIZE_8B   = 3'h3,
    SIZE_16B  = 3'h4,
    SIZE_32B  = 3'h5
  } dacr_size_e;

  typedef enum logic [2:0] {
    RPT_NORMAL = 3'h0,
    RPT_SDC    = 3'h1,
    RPT_DC     = 3'h2,
    RPT_SC     = 3'h3,
    RPT_RELOAD = 3'h5
  } dacr_rpt_e;

  typedef struct packed {
    logic [2:0]  ch;
    logic [31:0] src;
    logic [31:0] dst;
    logic        last;
  } dacr_desc_s;
endpackage : dacr_pkg
`default_nettype wire

// File: dacr_buf.sv
// Two-entry valid/ready buffer for transfer descriptors
`default_nettype none
module dacr_buf #(
  parameter int unsigned W     = 68,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [PW:0]   fill_q;
  logic          push;
  logic          pop;

  assign in_ready  = (fill_q != (PW+1)'(DEPTH));
  assign out_valid = (fill_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rptr_q];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      fill_q <= '0;
    end else begin
      if (push) wptr_q <= bump(wptr_q);
      if (pop) rptr_q <= bump(rptr_q);
      if (push && !pop) fill_q <= fill_q + 1'b1;
      else if (pop && !push) fill_q <= fill_q - 1'b1;
    end
  end

  // Storage needs no reset; an entry is only read after it was written
  always_ff @(posedge pclk) begin
    if (push) mem_q[wptr_q] <= in_data;
  end
endmodule : dacr_buf
`default_nettype wire

// File: dacr_sink.sv
// Descriptor sink model standing at the far side of the descriptor stream
`default_nettype none
module dacr_sink (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 desc_valid,
  input  wire dacr_pkg::dacr_desc_s desc,
  input  wire logic                 stall,
  output logic                      desc_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  dacr_pkg::dacr_desc_s got_q[$];

  // Stall is commanded by the bench so the buffer can be filled to refusal
  assign desc_ready = !stall;

  always @(posedge pclk) begin
    if (presetn && desc_valid && desc_ready) begin
      got_q.push_back(desc);
    end
  end
endmodule : dacr_sink
`default_nettype wire

// File: dacr_regs_tb.sv
// Self-checking testbench for the DMA address and count register block
`default_nettype none
module dacr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [3:0]           pstrb;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 step_valid;
  logic [2:0]           step_ch;
  logic                 step_ready;
  logic                 desc_valid;
  logic                 desc_ready;
  dacr_pkg::dacr_desc_s desc;
  logic [5:0]           chan_active;
  logic                 stall;
  int                   n_errors;
  int                   n_compared;
  logic [31:0]          v;
  logic                 e;
  dacr_pkg::dacr_desc_s d;

  dacr_regs u_dacr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_valid(step_valid), .step_ch(step_ch), .step_ready(step_ready), .desc_valid(desc_valid),
    .desc_ready(desc_ready), .desc(desc), .chan_active(chan_active));

  dacr_sink u_dacr_sink (.pclk(pclk), .presetn(presetn), .desc_valid(desc_valid), .desc(desc),
    .stall(stall), .desc_ready(desc_ready));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic close_out;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [67:0] seen, input logic [67:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic hang;
    n_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    close_out();
  endtask : hang

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) hang();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] dat);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, dat, r, x);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic x;
    apb(1'b0, a, 32'h0000_0000, r, x);
  endtask : rd

  // Working register k (0 src, 1 dst, 2 count); ch4 and ch5 skip one slot
  function automatic logic [11:0] wofs(input int ch, input int k);
    return dacr_pkg::OFS_SRC + 12'(4 * k) + dacr_pkg::CH_STRIDE * 12'(ch < 4 ? ch : ch + 1);
  endfunction : wofs

  function automatic logic [11:0] sofs(input int ch, input int k);
    return dacr_pkg::OFS_SH_SRC + 12'(4 * k) + dacr_pkg::CH_STRIDE * 12'(ch);
  endfunction : sofs

  task automatic step(input logic [2:0] c);
    int i;
    @(posedge pclk);
    step_valid <= 1'b1;
    step_ch    <= c;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (step_ready === 1'b1) break;
    end
    if (i == 50) hang();
    step_valid <= 1'b0;
  endtask : step

  task automatic take(output dacr_pkg::dacr_desc_s o);
    int i;
    for (i = 0; i < 50 && u_dacr_sink.got_q.size() == 0; i++) @(posedge pclk);
    if (i == 50) hang();
    o = u_dacr_sink.got_q.pop_front();
  endtask : take

  initial begin
    {psel, penable, pwrite, paddr, pwdata, step_valid, step_ch, stall} = '0;
    pstrb   = 4'hf;
    presetn = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      for (int k = 0; k < 3; k++) begin
        rd(wofs(c, k), v);
        check(v, dacr_pkg::RESET_WORD);
        if (c < 4) begin
          rd(sofs(c, k), v);
          check(v, dacr_pkg::RESET_WORD);
        end
      end
    end
    // A working write lands in the shadow too; a later shadow write stands apart
    for (int k = 0; k < 3; k++) begin
      wr(wofs(0, k), 32'h0000_1000 + 32'(k * 16));
      rd(sofs(0, k), v);
      check(v, 32'h0000_1000 + 32'(k * 16));
      wr(sofs(0, k), 32'h0000_3000);
      rd(wofs(0, k), v);
      check(v, 32'h0000_1000 + 32'(k * 16));
      rd(sofs(0, k), v);
      check(v, 32'h0000_3000);
    end
    wr(wofs(1, 1), 32'h0000_5004);
    rd(sofs(1, 1), v);
    check(v, 32'h0000_5004);
    wr(wofs(3, 2), 32'hffff_ffff);
    rd(wofs(3, 2), v);
    check(v, 32'h00ff_ffff);
    apb(1'b0, sofs(4, 0), 32'h0000_0000, v, e);
    check(e, 1'b1);
    // Longword run of three on ch0; sink stalls so the buffer fills and refuses
    wr(dacr_pkg::OFS_CFG, 32'h0000_0231);
    wr(wofs(0, 0), 32'h0000_1000);
    wr(wofs(0, 1), 32'h0000_2000);
    wr(wofs(0, 2), 32'h0000_0003);
    stall <= 1'b1;
    step(3'h0);
    step(3'h0);
    @(posedge pclk);
    check({step_ready, desc_valid}, 2'b01);
    stall <= 1'b0;
    step(3'h0);
    for (int i = 0; i < 3; i++) begin
      take(d);
      check(d, {3'h0, 32'h0000_1000 + 32'(4 * i), 32'h0000_2000 + 32'(4 * i), i == 2});
    end
    rd(wofs(0, 0), v);
    check(v, 32'h0000_100c);
    rd(wofs(0, 1), v);
    check(v, 32'h0000_200c);
    rd(wofs(0, 2), v);
    check(v, 32'h0000_0000);
    check(chan_active[0], 1'b0);
    // Repeat of source, destination and count on ch0
    wr(dacr_pkg::OFS_CFG, 32'h0200_0031);
    wr(wofs(0, 0), 32'h0000_0100);
    wr(wofs(0, 1), 32'h0000_0200);
    wr(wofs(0, 2), 32'h0000_0001);
    step(3'h0);
    take(d);
    check(d, {3'h0, 32'h0000_0100, 32'h0000_0200, 1'b1});
    for (int k = 0; k < 3; k++) begin
      rd(wofs(0, k), v);
      check(v, k == 2 ? 32'h0000_0001 : 32'h0000_0100 * 32'(k + 1));
    end
    check(chan_active[0], 1'b1);
    // Every unit size on ch0, count zero meaning the full range; dst held
    for (int s = 0; s < 6; s++) begin
      wr(dacr_pkg::OFS_CFG, 32'h0000_0011 | (32'(s) << 8));
      wr(wofs(0, 0), 32'h0000_0400);
      wr(wofs(0, 1), 32'h0000_0800);
      wr(wofs(0, 2), 32'h0000_0000);
      step(3'h0);
      take(d);
      check(d.last, 1'b0);
      rd(wofs(0, 0), v);
      check(v, 32'h0000_0400 + (32'h1 << s));
      rd(wofs(0, 1), v);
      check(v, 32'h0000_0800);
      rd(wofs(0, 2), v);
      check(v, 32'h00ff_ffff);
    end
    // Repeat of destination and count on ch0; source keeps advancing
    wr(dacr_pkg::OFS_CFG, 32'h0400_0031);
    wr(wofs(0, 0), 32'h0000_0500);
    wr(wofs(0, 1), 32'h0000_0600);
    wr(wofs(0, 2), 32'h0000_0002);
    wr(sofs(0, 1), 32'h0000_0680);
    step(3'h0);
    step(3'h0);
    take(d);
    take(d);
    check(d, {3'h0, 32'h0000_0501, 32'h0000_0601, 1'b1});
    rd(wofs(0, 0), v);
    check(v, 32'h0000_0502);
    rd(wofs(0, 1), v);
    check(v, 32'h0000_0680);
    rd(wofs(0, 2), v);
    check(v, 32'h0000_0002);
    close_out();
  end
endmodule : dacr_regs_tb
`default_nettype wire
